// >>> design/cgf_gating_control.sv
/*
 * graphics clock gating force control: apb register slave, override state,
 * per-clock gating requests with entry delay.
 * assumes apb master on CLK; clock-needed inputs synchronous to CLK.
 */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Contract
// - state bit one means gating is disabled
// - set register ones force gating off
// - clear register ones re-enable gating
// - set and clear share state bit positions
// - bit one main clock, bit zero reserved
// - bit three trace clock, needs capability one
// - bit two carries core clock override
// - shader stack override shares bit two
// - main core stack need capability zero
// - capability bit one reports trace support
// - trace fields read zero without support
// - capability bit zero reports gating support
// - eight-bit entry delay, zero to 255 cycles
module cgf_gating_control #(
    parameter bit GATING_SUPPORTED = 1'b1,
    parameter bit TRACE_SUPPORTED  = 1'b1
)
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic [31:0]      PRDATA,
    // clock demand from the gated domains
    input  wire logic        MAIN_CLOCK_NEEDED,
    input  wire logic        CORE_CLOCK_NEEDED,
    input  wire logic        TRACE_CLOCK_NEEDED,
    // overrides and gate requests
    output logic             MAIN_CLOCK_OVERRIDE,
    output logic             CORE_CLOCK_OVERRIDE,
    output logic             SHADER_STACK_CLOCK_OVERRIDE,
    output logic             TRACE_CLOCK_OVERRIDE,
    output logic             MAIN_CLOCK_GATE_REQ,
    output logic             CORE_CLOCK_GATE_REQ,
    output logic             TRACE_CLOCK_GATE_REQ
);

    // ************************************************************
    // bus decode
    // ************************************************************
    cgf_pkg::cgf_apb_req_type req;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [7:0]  delay_reg;
    logic [7:0]  delay_next;
    logic [3:0]  state_bits;
    logic [3:0]  present_bits;
    logic [3:0]  set_pulse;
    logic [3:0]  clear_pulse;
    logic [31:0] cap_word;
    logic        access;
    logic        wr_access;
    logic        rd_access;
    logic        hit_state;
    logic        hit_set;
    logic        hit_clear;
    logic        hit_cap;
    logic        hit_delay;
    logic        mapped;
    logic        cap_gating;
    logic        cap_trace;
    logic        in_setup;

    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] offset);
        addr_hit = (addr[11:2] == offset[11:2]);
    endfunction : addr_hit

    assign req        = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE, paddr: PADDR, pwdata: PWDATA};
    assign access     = req.psel & req.penable;
    assign wr_access  = access & req.pwrite;
    assign rd_access  = req.psel & ~req.penable & ~req.pwrite;
    assign in_setup   = req.psel & ~req.penable;
    assign hit_state  = addr_hit(req.paddr, cgf_pkg::FORCE_STATE_OFFSET);
    assign hit_set    = addr_hit(req.paddr, cgf_pkg::FORCE_SET_OFFSET);
    assign hit_clear  = addr_hit(req.paddr, cgf_pkg::FORCE_CLEAR_OFFSET);
    assign hit_cap    = addr_hit(req.paddr, cgf_pkg::CAPABILITIES_OFFSET);
    assign hit_delay  = addr_hit(req.paddr, cgf_pkg::ENTRY_DELAY_OFFSET);
    assign mapped     = hit_state | hit_set | hit_clear | hit_cap | hit_delay;

    // ************************************************************
    // capabilities
    // ************************************************************
    assign cap_gating = GATING_SUPPORTED;
    assign cap_trace  = TRACE_SUPPORTED;

    always_comb
    begin
        cap_word = 32'h0000_0000;
        cap_word[cgf_pkg::CAP_GATING_BIT] = cap_gating;
        cap_word[cgf_pkg::CAP_TRACE_BIT]  = cap_trace;
    end

    // ************************************************************
    // override state
    // ************************************************************
    // bit 0 reserved, 1 main, 2 core and shader stack, 3 trace
    assign present_bits = {cap_trace, cap_gating, cap_gating, 1'b0};
    assign set_pulse    = (wr_access & hit_set)   ? req.pwdata[3:0] : 4'h0;
    assign clear_pulse  = (wr_access & hit_clear) ? req.pwdata[3:0] : 4'h0;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_force
            cgf_force_bit u_bit
            (
                .clk         (CLK),
                .reset       (RESET),
                .present     (present_bits[gi]),
                .set_pulse   (set_pulse[gi]),
                .clear_pulse (clear_pulse[gi]),
                .state       (state_bits[gi])
            );
        end
    endgenerate

    assign MAIN_CLOCK_OVERRIDE         = state_bits[cgf_pkg::MAIN_CLOCK_BIT];
    assign CORE_CLOCK_OVERRIDE         = state_bits[cgf_pkg::CORE_CLOCK_BIT];
    assign SHADER_STACK_CLOCK_OVERRIDE = state_bits[cgf_pkg::CORE_CLOCK_BIT];
    assign TRACE_CLOCK_OVERRIDE        = state_bits[cgf_pkg::TRACE_CLOCK_BIT];

    // ************************************************************
    // entry delay
    // ************************************************************
    assign delay_next = (wr_access & hit_delay & cap_gating)
                      ? req.pwdata[cgf_pkg::ENTRY_DELAY_LSB +: cgf_pkg::ENTRY_DELAY_WIDTH]
                      : delay_reg;

    always_ff @(posedge CLK)
    begin
        if (RESET)
            delay_reg <= cgf_pkg::ENTRY_DELAY_RESET;
        else
            delay_reg <= delay_next;
    end

    cgf_delay_timer #(.WIDTH(cgf_pkg::ENTRY_DELAY_WIDTH)) u_main_timer
    (
        .clk          (CLK),
        .reset        (RESET),
        .delay        (delay_reg),
        .clock_needed (MAIN_CLOCK_NEEDED | ~cap_gating),
        .forced       (MAIN_CLOCK_OVERRIDE),
        .gate_request (MAIN_CLOCK_GATE_REQ)
    );

    cgf_delay_timer #(.WIDTH(cgf_pkg::ENTRY_DELAY_WIDTH)) u_core_timer
    (
        .clk          (CLK),
        .reset        (RESET),
        .delay        (delay_reg),
        .clock_needed (CORE_CLOCK_NEEDED | ~cap_gating),
        .forced       (CORE_CLOCK_OVERRIDE),
        .gate_request (CORE_CLOCK_GATE_REQ)
    );

    cgf_delay_timer #(.WIDTH(cgf_pkg::ENTRY_DELAY_WIDTH)) u_trace_timer
    (
        .clk          (CLK),
        .reset        (RESET),
        .delay        (delay_reg),
        .clock_needed (TRACE_CLOCK_NEEDED | ~cap_trace),
        .forced       (TRACE_CLOCK_OVERRIDE),
        .gate_request (TRACE_CLOCK_GATE_REQ)
    );

    // ************************************************************
    // read data
    // ************************************************************
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (rd_access & hit_state)
            rdata_next[3:0] = state_bits;
        else if (rd_access & hit_cap)
            rdata_next = cap_word;
        else if (rd_access & hit_delay)
            rdata_next[cgf_pkg::ENTRY_DELAY_LSB +: cgf_pkg::ENTRY_DELAY_WIDTH] = delay_reg;
        else if (in_setup)
            rdata_next = 32'h0000_0000;
        else
            rdata_next = rdata_reg;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            rdata_reg    <= 32'h0000_0000;
        end
        else
        begin
            rdata_reg    <= rdata_next;
        end
    end

    assign PRDATA  = rdata_reg;
    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~mapped;

    // ************************************************************
    // checks
    // ************************************************************
    property p_set_forces;
        @(posedge CLK) disable iff (RESET)
        (wr_access & hit_set & req.pwdata[cgf_pkg::MAIN_CLOCK_BIT] & cap_gating)
            |=> MAIN_CLOCK_OVERRIDE;
    endproperty
    a_set_forces: assert property (p_set_forces) else $error("set write did not force main override");

    property p_clear_releases;
        @(posedge CLK) disable iff (RESET)
        (wr_access & hit_clear & req.pwdata[cgf_pkg::CORE_CLOCK_BIT] & ~(wr_access & hit_set))
            |=> ~CORE_CLOCK_OVERRIDE;
    endproperty
    a_clear_releases: assert property (p_clear_releases) else $error("clear write left core override");

    property p_zero_bits_hold;
        @(posedge CLK) disable iff (RESET)
        (wr_access & (hit_set | hit_clear) & ~req.pwdata[cgf_pkg::TRACE_CLOCK_BIT])
            |=> $stable(TRACE_CLOCK_OVERRIDE);
    endproperty
    a_zero_bits_hold: assert property (p_zero_bits_hold) else $error("zero bit changed trace override");

    property p_bit0_reserved;
        @(posedge CLK) disable iff (RESET)
        1'b1 |-> (state_bits[0] == 1'b0);
    endproperty
    a_bit0_reserved: assert property (p_bit0_reserved) else $error("reserved bit zero set");

    property p_trace_absent;
        @(posedge CLK) disable iff (RESET)
        ~cap_trace |-> ~TRACE_CLOCK_OVERRIDE;
    endproperty
    a_trace_absent: assert property (p_trace_absent) else $error("trace override without support");

    property p_stack_core;
        @(posedge CLK) disable iff (RESET)
        1'b1 |-> (SHADER_STACK_CLOCK_OVERRIDE == CORE_CLOCK_OVERRIDE);
    endproperty
    a_stack_core: assert property (p_stack_core) else $error("stack and core overrides differ");

    property p_state_read;
        @(posedge CLK) disable iff (RESET)
        (rd_access & hit_state) |=> (PRDATA[3:0] == $past(state_bits)) && (PRDATA[31:4] == 28'h0);
    endproperty
    a_state_read: assert property (p_state_read) else $error("state read wrong");

    property p_cap_read;
        @(posedge CLK) disable iff (RESET)
        (rd_access & hit_cap) |=> (PRDATA == {30'h0, cap_trace, cap_gating});
    endproperty
    a_cap_read: assert property (p_cap_read) else $error("capability read wrong");

    property p_reset_clear;
        @(posedge CLK)
        $past(RESET) |-> (state_bits == cgf_pkg::FORCE_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("override not clear after reset");

    property p_forced_no_gate;
        @(posedge CLK) disable iff (RESET)
        MAIN_CLOCK_OVERRIDE ##1 MAIN_CLOCK_OVERRIDE |-> ~MAIN_CLOCK_GATE_REQ;
    endproperty
    a_forced_no_gate: assert property (p_forced_no_gate) else $error("gate request while forced");

    property p_trace_set;
        @(posedge CLK) disable iff (RESET)
        (wr_access & hit_set & req.pwdata[cgf_pkg::TRACE_CLOCK_BIT] & cap_trace)
            |=> TRACE_CLOCK_OVERRIDE;
    endproperty
    a_trace_set: assert property (p_trace_set) else $error("set write did not force trace override");

    property p_core_set;
        @(posedge CLK) disable iff (RESET)
        (wr_access & hit_set & req.pwdata[cgf_pkg::CORE_CLOCK_BIT] & cap_gating)
            |=> CORE_CLOCK_OVERRIDE && SHADER_STACK_CLOCK_OVERRIDE;
    endproperty
    a_core_set: assert property (p_core_set) else $error("set write did not force core override");

    property p_main_clear;
        @(posedge CLK) disable iff (RESET)
        (wr_access & hit_clear & req.pwdata[cgf_pkg::MAIN_CLOCK_BIT])
            |=> ~MAIN_CLOCK_OVERRIDE;
    endproperty
    a_main_clear: assert property (p_main_clear) else $error("clear write left main override");

    property p_gating_absent;
        @(posedge CLK) disable iff (RESET)
        ~cap_gating
            |-> ~MAIN_CLOCK_OVERRIDE && ~CORE_CLOCK_OVERRIDE && ~MAIN_CLOCK_GATE_REQ && ~CORE_CLOCK_GATE_REQ;
    endproperty
    a_gating_absent: assert property (p_gating_absent) else $error("gating active without support");

    property p_wo_read_zero;
        @(posedge CLK) disable iff (RESET)
        (rd_access & (hit_set | hit_clear))
            |=> (PRDATA == 32'h0000_0000);
    endproperty
    a_wo_read_zero: assert property (p_wo_read_zero) else $error("set or clear read not zero");

    property p_delay_read;
        @(posedge CLK) disable iff (RESET)
        (rd_access & hit_delay)
            |=> (PRDATA[31:24] == $past(delay_reg)) && (PRDATA[23:0] == 24'h00_0000);
    endproperty
    a_delay_read: assert property (p_delay_read) else $error("entry delay read wrong");

    property p_delay_zero_gate;
        @(posedge CLK) disable iff (RESET)
        (~MAIN_CLOCK_NEEDED & ~MAIN_CLOCK_OVERRIDE & cap_gating & (delay_reg == 8'h00))
            |=> MAIN_CLOCK_GATE_REQ;
    endproperty
    a_delay_zero_gate: assert property (p_delay_zero_gate) else $error("no gate request at zero delay");

    property p_needed_drops;
        @(posedge CLK) disable iff (RESET)
        MAIN_CLOCK_NEEDED
            |=> ~MAIN_CLOCK_GATE_REQ;
    endproperty
    a_needed_drops: assert property (p_needed_drops) else $error("gate request while clock needed");

    property p_bare_delay_hold;
        @(posedge CLK) disable iff (RESET)
        ~cap_gating
            |-> (delay_reg == cgf_pkg::ENTRY_DELAY_RESET);
    endproperty
    a_bare_delay_hold: assert property (p_bare_delay_hold) else $error("entry delay written without support");

    property p_trace_gate_absent;
        @(posedge CLK) disable iff (RESET)
        ~cap_trace
            |-> ~TRACE_CLOCK_GATE_REQ;
    endproperty
    a_trace_gate_absent: assert property (p_trace_gate_absent) else $error("trace gate request without support");

    c_set_main: cover property (@(posedge CLK) wr_access & hit_set ##1 MAIN_CLOCK_OVERRIDE);
    c_clear_core: cover property (@(posedge CLK) CORE_CLOCK_OVERRIDE ##1 ~CORE_CLOCK_OVERRIDE);
    c_gate_req: cover property (@(posedge CLK) $rose(MAIN_CLOCK_GATE_REQ));
    c_bad_addr: cover property (@(posedge CLK) PSLVERR);
    c_delay_write: cover property (@(posedge CLK) wr_access & hit_delay & cap_gating);

endmodule : cgf_gating_control

// >>> design/cgf_pkg.sv
/*
 * package for the graphics clock gating force control block:
 * register offsets, field positions, reset values, bus carriers.
 * assumes an apb slave port with 32-bit data and 12-bit word-aligned byte addresses.
 */
package cgf_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [11:0] FORCE_STATE_OFFSET  = 12'ha00;
    localparam logic [11:0] FORCE_SET_OFFSET    = 12'ha04;
    localparam logic [11:0] FORCE_CLEAR_OFFSET  = 12'ha08;
    localparam logic [11:0] CAPABILITIES_OFFSET = 12'hfbc;
    localparam logic [11:0] ENTRY_DELAY_OFFSET  = 12'ha0c;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int MAIN_CLOCK_BIT    = 1;
    localparam int CORE_CLOCK_BIT    = 2;
    localparam int TRACE_CLOCK_BIT   = 3;
    localparam int CAP_GATING_BIT    = 0;
    localparam int CAP_TRACE_BIT     = 1;
    localparam int ENTRY_DELAY_LSB   = 24;
    localparam int ENTRY_DELAY_WIDTH = 8;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [3:0] FORCE_RESET       = 4'h0;
    localparam logic [7:0] ENTRY_DELAY_RESET = 8'h00;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } cgf_apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cgf_apb_rsp_type;

endpackage : cgf_pkg

// >>> design/cgf_force_bit.sv
/*
 * one override state bit with set and clear strobes.
 * assumes strobes are single-cycle pulses on CLK.
 */
`timescale 1ns/1ps
module cgf_force_bit
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // control
    input  wire logic present,
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    // state
    output logic      state
);

    logic state_reg;
    logic state_next;

    // set wins over clear; absent bit stays zero
    assign state_next = present & (set_pulse | (state_reg & ~clear_pulse));
    assign state      = state_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
            state_reg <= 1'b0;
        else
            state_reg <= state_next;
    end

endmodule : cgf_force_bit

// >>> design/cgf_delay_timer.sv
/*
 * gating entry delay counter: counts idle cycles before a gate request.
 * assumes clock_needed is synchronous to clk.
 */
`timescale 1ns/1ps
module cgf_delay_timer #(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // control
    input  wire logic [WIDTH-1:0] delay,
    input  wire logic             clock_needed,
    input  wire logic             forced,
    // result
    output logic                  gate_request
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic             req_reg;
    logic             req_next;
    logic             expired;

    assign expired    = (count_reg >= delay);
    assign count_next = (clock_needed | forced) ? '0 : (expired ? count_reg : count_reg + WIDTH'(1));
    // request once delay idle cycles have passed
    assign req_next   = ~clock_needed & ~forced & expired;
    assign gate_request = req_reg;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            count_reg <= '0;
            req_reg   <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            req_reg   <= req_next;
        end
    end

endmodule : cgf_delay_timer

// >>> verification/tb_cgf_gating_control.sv
/*
 * self-checking bench for the clock gating force control block: apb register
 * access, override state, capability bits, entry delay and gate requests.
 * assumes the cgf_pkg package and a zero-wait apb slave.
 * a second instance runs with gating and trace support absent.
 */
`timescale 1ns/1ps
module tb_cgf_gating_control;

    // ************************************************************
    // signals
    // ************************************************************
    localparam int LIMIT = 20000;
    logic                    clk;
    logic                    reset;
    cgf_pkg::cgf_apb_req_type req;
    cgf_pkg::cgf_apb_rsp_type rsp_full;
    cgf_pkg::cgf_apb_rsp_type rsp_bare;
    logic [2:0]              needed;
    logic [3:0]              ovr_full;
    logic [3:0]              ovr_bare;
    logic [2:0]              greq_full;
    logic [2:0]              greq_bare;
    logic [31:0]             got_full;
    logic [31:0]             got_bare;
    logic [1:0]              err_full;
    int                      num_errors = 0;
    int                      total_checks = 0;
    int                      cycles = 0;

    // ************************************************************
    // design instances
    // ************************************************************
    cgf_gating_control #(.GATING_SUPPORTED(1'b1), .TRACE_SUPPORTED(1'b1)) u_cgf_gating_control
    (
        .CLK(clk), .RESET(reset), .PSEL(req.psel), .PENABLE(req.penable), .PWRITE(req.pwrite),
        .PADDR(req.paddr), .PWDATA(req.pwdata), .PREADY(rsp_full.pready), .PSLVERR(rsp_full.pslverr),
        .PRDATA(rsp_full.prdata), .MAIN_CLOCK_NEEDED(needed[0]), .CORE_CLOCK_NEEDED(needed[1]),
        .TRACE_CLOCK_NEEDED(needed[2]), .MAIN_CLOCK_OVERRIDE(ovr_full[0]), .CORE_CLOCK_OVERRIDE(ovr_full[1]),
        .SHADER_STACK_CLOCK_OVERRIDE(ovr_full[2]), .TRACE_CLOCK_OVERRIDE(ovr_full[3]),
        .MAIN_CLOCK_GATE_REQ(greq_full[0]), .CORE_CLOCK_GATE_REQ(greq_full[1]),
        .TRACE_CLOCK_GATE_REQ(greq_full[2])
    );

    cgf_gating_control #(.GATING_SUPPORTED(1'b0), .TRACE_SUPPORTED(1'b0)) u_cgf_gating_control_bare
    (
        .CLK(clk), .RESET(reset), .PSEL(req.psel), .PENABLE(req.penable), .PWRITE(req.pwrite),
        .PADDR(req.paddr), .PWDATA(req.pwdata), .PREADY(rsp_bare.pready), .PSLVERR(rsp_bare.pslverr),
        .PRDATA(rsp_bare.prdata), .MAIN_CLOCK_NEEDED(needed[0]), .CORE_CLOCK_NEEDED(needed[1]),
        .TRACE_CLOCK_NEEDED(needed[2]), .MAIN_CLOCK_OVERRIDE(ovr_bare[0]), .CORE_CLOCK_OVERRIDE(ovr_bare[1]),
        .SHADER_STACK_CLOCK_OVERRIDE(ovr_bare[2]), .TRACE_CLOCK_OVERRIDE(ovr_bare[3]),
        .MAIN_CLOCK_GATE_REQ(greq_bare[0]), .CORE_CLOCK_GATE_REQ(greq_bare[1]),
        .TRACE_CLOCK_GATE_REQ(greq_bare[2])
    );

    // ************************************************************
    // clock, timeout, helpers
    // ************************************************************
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles >= LIMIT)
        begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [31:0] ovr_state(input logic [3:0] ovr);
        return {28'h0, ovr[3], ovr[1], ovr[0], 1'b0};
    endfunction : ovr_state

    // one apb transfer; read data and error taken at the edge where pready is seen
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (rsp_full.pready !== 1'b1 && n < 16);
        check({31'h0, rsp_full.pready & rsp_bare.pready}, 32'h1);
        got_full = rsp_full.prdata;
        got_bare = rsp_bare.prdata;
        err_full = {rsp_bare.pslverr, rsp_full.pslverr};
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic read_state(input logic [31:0] exp);
        apb(1'b0, cgf_pkg::FORCE_STATE_OFFSET, 32'h0);
        check(got_full, exp);
        check(ovr_state(ovr_full), exp);
        check({31'h0, ovr_full[2]}, {31'h0, ovr_full[1]});
        check(got_bare, 32'h0);
        check({28'h0, ovr_bare}, 32'h0);
        check({30'h0, err_full}, 32'h0);
    endtask : read_state

    // ************************************************************
    // tests
    // ************************************************************
    initial
    begin
        logic [31:0] exp;
        int          n;
        logic [7:0]  dly [3];
        dly = '{8'hff, 8'h05, 8'h00};
        req = '0;
        needed = 3'b111;
        reset = 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        read_state(32'h0);
        check({29'h0, greq_full}, 32'h0);
        $display("test reset done");
        apb(1'b0, cgf_pkg::CAPABILITIES_OFFSET, 32'h0);
        check(got_full, 32'h3);
        check(got_bare, 32'h0);
        $display("test capabilities done");
        exp = 32'h0;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, cgf_pkg::FORCE_SET_OFFSET, 32'h1 << i);
            if (i > 0)
                exp[i] = 1'b1;
            read_state(exp);
        end
        $display("test force set done");
        apb(1'b1, cgf_pkg::FORCE_CLEAR_OFFSET, 32'h0);
        read_state(32'he);
        apb(1'b1, cgf_pkg::FORCE_CLEAR_OFFSET, 32'h4);
        read_state(32'ha);
        apb(1'b1, cgf_pkg::FORCE_CLEAR_OFFSET, 32'hffffffff);
        read_state(32'h0);
        apb(1'b1, cgf_pkg::FORCE_SET_OFFSET, 32'hffffffff);
        read_state(32'he);
        apb(1'b0, cgf_pkg::FORCE_SET_OFFSET, 32'h0);
        check(got_full, 32'h0);
        $display("test force clear done");
        apb(1'b0, 12'h010, 32'h0);
        check({30'h0, err_full}, 32'h3);
        check(got_full, 32'h0);
        apb(1'b1, cgf_pkg::FORCE_STATE_OFFSET, 32'h0);
        read_state(32'he);
        apb(1'b1, cgf_pkg::FORCE_CLEAR_OFFSET, 32'he);
        $display("test unmapped done");
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, cgf_pkg::ENTRY_DELAY_OFFSET, {dly[i], 24'h0});
            apb(1'b0, cgf_pkg::ENTRY_DELAY_OFFSET, 32'h0);
            check(got_full, {dly[i], 24'h0});
            check(got_bare, 32'h0);
            @(posedge clk);
            needed <= 3'b000;
            n = 0;
            do
            begin
                @(posedge clk);
                #1;
                n++;
            end
            while (greq_full[0] !== 1'b1 && n < 300);
            check(32'(n), 32'(dly[i]) + 32'h1);
            check({29'h0, greq_full}, 32'h7);
            check({29'h0, greq_bare}, 32'h0);
            @(posedge clk);
            needed <= 3'b111;
            @(posedge clk);
            #1;
            check({29'h0, greq_full}, 32'h0);
        end
        apb(1'b1, cgf_pkg::FORCE_SET_OFFSET, 32'h2);
        @(posedge clk);
        needed <= 3'b000;
        repeat (4) @(posedge clk);
        #1;
        check({29'h0, greq_full}, 32'h6);
        $display("test entry delay done");
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        read_state(32'h0);
        $display("test mid-run reset done");
        summarize();
    end

endmodule : tb_cgf_gating_control
